// >>> shared/emp_pkg.sv
// Shared constants and carrier types for the external memory port block
package emp_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int SPACE_W    = 2;              // Chip-select space index width
  localparam int NUM_SPACES = 1 << SPACE_W;   // Chip-select spaces
  localparam int ADDR_W     = 20;             // Word address, pin bits 21 down to 2
  localparam int DATA_W     = 32;
  localparam int BE_W       = 4;
  localparam int CNT_W      = 6;              // Phase counter, wide enough for strobe

  // ----------------------------------------------------------------------
  // Reset values of the pins, and phase counter constants
  // ----------------------------------------------------------------------
  localparam logic [NUM_SPACES-1:0] CE_IDLE   = {NUM_SPACES{1'b1}};
  localparam logic [BE_W-1:0]       BE_IDLE   = 4'hf;
  localparam logic [ADDR_W-1:0]     ADDR_RST  = 20'h00000;
  localparam logic [DATA_W-1:0]     DATA_RST  = 32'h00000000;
  localparam logic [CNT_W-1:0]      CNT_ZERO  = 6'h00;
  localparam logic [CNT_W-1:0]      CNT_ONE   = 6'h01;

  // ----------------------------------------------------------------------
  // Per-space programmed timing and mode
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       sync_mode;            // 1: programmable synchronous cycles
    logic [3:0] read_setup_cycles;
    logic [5:0] read_strobe_cycles;
    logic [2:0] read_hold_cycles;
    logic [3:0] write_setup_cycles;
    logic [5:0] write_strobe_cycles;
    logic [2:0] write_hold_cycles;
    logic [1:0] sync_read_latency;
    logic [1:0] sync_write_latency;
    logic       select_extend;
    logic       read_enable_mode;
    logic       sync_clock_select;    // 0: port clock a, 1: port clock b
  } emp_space_cfg_s;

  // One access request from the core side
  typedef struct packed {
    logic               write;
    logic [SPACE_W-1:0] space;
    logic [ADDR_W-1:0]  addr;
    logic [BE_W-1:0]    byte_enable;  // Active high, inverted at the pins
    logic [DATA_W-1:0]  wdata;
  } emp_req_s;

  // ----------------------------------------------------------------------
  // Access sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_ASETUP  = 3'b001,
    ST_ASTROBE = 3'b010,
    ST_AHOLD   = 3'b011,
    ST_SCMD    = 3'b100,
    ST_SDESEL  = 3'b101
  } emp_state_e;

endpackage : emp_pkg

// >>> design/emp_port.sv
// External memory port sequencer for asynchronous and synchronous accesses
//
// Behaviour
// - Read selects stand valid read_setup_cycles port clocks before read strobe falls.
// - Read selects stay valid read_hold_cycles port clocks after read strobe rises.
// - Write selects stand valid write_setup_cycles port clocks before write strobe falls.
// - Write selects stay valid write_hold_cycles port clocks after write strobe rises.
// - Setup, strobe and hold counts are programmed separately per chip-select space.
// - Async counts use port clock a; strobes change only after its rising edges.
// - Ready passes a synchroniser and is acted on at a port clock rising edge.
// - Chip enable, byte enables, address, output enable, write data are selects.
// - Async read data is captured when read strobe rises.
// - Async accesses use shared pins as output enable, read strobe, write strobe.
// - Sync accesses use shared pins as address strobe/read enable, output, write enable.
// - Per-space sync read latency of 0 to 3 cycles.
// - Per-space sync write latency of 0 to 3 cycles.
// - Select extend 0: chip enable drops after the last command is issued.
// - Select extend 1: chip enable stays low while sync output enable is low.
// - Read enable mode 0: address strobe function with deselect cycles.
// - Read enable mode 1: read enable function without deselect cycles.
// - Per-space clock select picks port clock a or b for sync accesses.
// - Sync pins launch on, and read data samples at, selected clock rising edges.
`timescale 1ns/1ns
`default_nettype none

module emp_port (
  input  wire logic                                   i_clock,
  input  wire logic                                   i_rst,
  input  wire emp_pkg::emp_space_cfg_s                i_space_cfg [emp_pkg::NUM_SPACES],
  input  wire logic                                   i_req_valid,
  input  wire emp_pkg::emp_req_s                      i_req,
  output logic                                        o_req_ready,
  output logic                                        o_rdata_valid,
  output logic [emp_pkg::DATA_W-1:0]                  o_rdata,
  input  wire logic                                   i_ext_clock_out_a,
  input  wire logic                                   i_ext_clock_out_b,
  input  wire logic                                   i_async_ready,
  output logic [emp_pkg::NUM_SPACES-1:0]              o_chip_enable_n,
  output logic [emp_pkg::BE_W-1:0]                    o_byte_enable_n,
  output logic [emp_pkg::ADDR_W-1:0]                  o_addr,
  output logic [emp_pkg::DATA_W-1:0]                  o_data,
  output logic                                        o_data_oe,
  input  wire logic [emp_pkg::DATA_W-1:0]             i_data,
  output logic                                        o_strobe_rd_n,
  output logic                                        o_output_enable_n,
  output logic                                        o_strobe_wr_n
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // A programmed count of zero is stretched to one port clock
  // Load is one less than the count: the tick that finds zero ends the phase
  function automatic logic [emp_pkg::CNT_W-1:0] cnt_load(
    input logic [emp_pkg::CNT_W-1:0] v
  );
    cnt_load = (v == emp_pkg::CNT_ZERO) ? emp_pkg::CNT_ZERO : v - emp_pkg::CNT_ONE;
  endfunction : cnt_load

  // Port clock edge that paces a space
  // Asynchronous spaces always follow port clock a; only sync spaces may pick b
  function automatic logic pick_tick(
    input emp_pkg::emp_space_cfg_s c,
    input logic                    ta,
    input logic                    tb
  );
    pick_tick = (c.sync_mode && c.sync_clock_select) ? tb : ta;
  endfunction : pick_tick

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // The port clocks are sampled as data, never used as clocks. Each of
  // their high and low phases must last at least two system clocks, or
  // an edge is lost; a faster port clock needs a different scheme.
  // Read data passes the same two flops, so it must stand steady for a
  // few system clocks before the capture tick.
  // Ready has no more than these two flops of delay before it is used.
  logic                        clka_s1_q;
  logic                        clka_s2_q;
  logic                        clka_s3_q;
  logic                        clkb_s1_q;
  logic                        clkb_s2_q;
  logic                        clkb_s3_q;
  logic                        rdy_s1_q;
  logic                        rdy_s2_q;
  logic [emp_pkg::DATA_W-1:0]  din_s1_q;
  logic [emp_pkg::DATA_W-1:0]  din_s2_q;
  logic                        tick_a;
  logic                        tick_b;

  // Two flops on every pin input; edge detect only looks past the second
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      clka_s1_q <= 1'b0;
      clka_s2_q <= 1'b0;
      clka_s3_q <= 1'b0;
      clkb_s1_q <= 1'b0;
      clkb_s2_q <= 1'b0;
      clkb_s3_q <= 1'b0;
      rdy_s1_q  <= 1'b0;
      rdy_s2_q  <= 1'b0;
      din_s1_q  <= emp_pkg::DATA_RST;
      din_s2_q  <= emp_pkg::DATA_RST;
    end else begin
      clka_s1_q <= i_ext_clock_out_a;
      clka_s2_q <= clka_s1_q;
      clka_s3_q <= clka_s2_q;
      clkb_s1_q <= i_ext_clock_out_b;
      clkb_s2_q <= clkb_s1_q;
      clkb_s3_q <= clkb_s2_q;
      rdy_s1_q  <= i_async_ready;
      rdy_s2_q  <= rdy_s1_q;
      din_s1_q  <= i_data;
      din_s2_q  <= din_s1_q;
    end
  end

  // Rising edges of the port clocks as one-cycle ticks
  assign tick_a = clka_s2_q & ~clka_s3_q;
  assign tick_b = clkb_s2_q & ~clkb_s3_q;

  // ----------------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------------
  // Access state, latched space settings and the running phase count
  emp_pkg::emp_state_e         state_q;
  emp_pkg::emp_space_cfg_s     cfg_q;
  emp_pkg::emp_space_cfg_s     req_cfg;
  logic                        write_q;
  logic [emp_pkg::DATA_W-1:0]  wdata_q;
  logic [emp_pkg::CNT_W-1:0]   cnt_q;
  logic                        ready_q;
  logic                        tick_req;
  logic                        tick;
  logic                        accept;

  // Requests are taken only on a tick of the space's own port clock, so the
  // first pin change of an access already sits on a port clock rising edge;
  // a waiting request is never dropped, it simply stays until that tick
  assign req_cfg  = i_space_cfg[i_req.space];
  assign tick_req = pick_tick(req_cfg, tick_a, tick_b);
  assign tick     = pick_tick(cfg_q, tick_a, tick_b);
  assign accept   = (state_q == emp_pkg::ST_IDLE) && i_req_valid && ready_q && tick_req;

  // Flow of an access, at most one state change per port clock tick:
  //   asynchronous: IDLE -> ASETUP -> ASTROBE -> AHOLD -> IDLE
  //   synchronous:  IDLE -> SCMD -> (SDESEL when deselects are wanted) -> IDLE
  // The counter is loaded with the programmed count minus one, so a count
  // of N keeps a phase for N ticks; zero is treated as one, since a phase
  // of no length would let selects and strobe change on the same edge.
  // In synchronous accesses the counter holds the latency instead: write
  // data goes out on the tick that finds one (at the take for latency 0);
  // read data is taken on the tick that finds zero.
  //
  // Every pin change is made on a port clock tick, so all pins launch
  // from the same rising edge; the cost is up to one port clock of latency
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_q           <= emp_pkg::ST_IDLE;
      cfg_q             <= '0;
      write_q           <= 1'b0;
      wdata_q           <= emp_pkg::DATA_RST;
      cnt_q             <= emp_pkg::CNT_ZERO;
      ready_q           <= 1'b1;
      o_chip_enable_n   <= emp_pkg::CE_IDLE;
      o_byte_enable_n   <= emp_pkg::BE_IDLE;
      o_addr            <= emp_pkg::ADDR_RST;
      o_data            <= emp_pkg::DATA_RST;
      o_data_oe         <= 1'b0;
      o_strobe_rd_n     <= 1'b1;
      o_output_enable_n <= 1'b1;
      o_strobe_wr_n     <= 1'b1;
      o_rdata_valid     <= 1'b0;
      o_rdata           <= emp_pkg::DATA_RST;
    end else begin
      o_rdata_valid <= 1'b0;
      case (state_q)
        // Waiting for a request: all selects launch together at the take,
        // so the setup count starts from the same edge for every select pin
        emp_pkg::ST_IDLE: begin
          if (accept) begin
            ready_q         <= 1'b0;
            cfg_q           <= req_cfg;
            write_q         <= i_req.write;
            wdata_q         <= i_req.wdata;
            o_chip_enable_n <= ~(emp_pkg::NUM_SPACES'(1) << i_req.space);
            o_byte_enable_n <= ~i_req.byte_enable;
            o_addr          <= i_req.addr;
            if (req_cfg.sync_mode) begin
              // Command edge: strobe pins take their synchronous roles
              o_strobe_rd_n     <= i_req.write && req_cfg.read_enable_mode;
              o_output_enable_n <= i_req.write;
              o_strobe_wr_n     <= ~i_req.write;
              if (i_req.write) begin
                cnt_q <= emp_pkg::CNT_W'(req_cfg.sync_write_latency);
                if (req_cfg.sync_write_latency == 2'h0) begin
                  o_data    <= i_req.wdata;
                  o_data_oe <= 1'b1;
                end
              end else begin
                cnt_q <= emp_pkg::CNT_W'(req_cfg.sync_read_latency);
              end
              state_q <= emp_pkg::ST_SCMD;
            end else begin
              // Async: output enable and write data are selects too
              o_output_enable_n <= i_req.write;
              o_data            <= i_req.wdata;
              o_data_oe         <= i_req.write;
              cnt_q   <= cnt_load(emp_pkg::CNT_W'(i_req.write ? req_cfg.write_setup_cycles
                                                              : req_cfg.read_setup_cycles));
              state_q <= emp_pkg::ST_ASETUP;
            end
          end
        end

        // Setup phase: selects stand still while the counter runs down;
        // the strobe opens on the tick where the count has expired
        emp_pkg::ST_ASETUP: begin
          if (tick) begin
            if (cnt_q == emp_pkg::CNT_ZERO) begin
              // Selects have stood the full setup count; open the strobe
              o_strobe_rd_n <= write_q;
              o_strobe_wr_n <= ~write_q;
              cnt_q   <= cnt_load(write_q ? cfg_q.write_strobe_cycles
                                          : cfg_q.read_strobe_cycles);
              state_q <= emp_pkg::ST_ASTROBE;
            end else begin
              cnt_q <= cnt_q - emp_pkg::CNT_ONE;
            end
          end
        end

        // Strobe phase: ready is only looked at once the programmed count
        // has run out, so a memory that drops ready early costs nothing.
        // Read data comes from the synchronised pins on the edge that ends
        // the strobe, so the strobe must cover the memory's access time
        emp_pkg::ST_ASTROBE: begin
          if (tick) begin
            if (cnt_q != emp_pkg::CNT_ZERO) begin
              cnt_q <= cnt_q - emp_pkg::CNT_ONE;
            end else if (rdy_s2_q) begin
              // Ready low at the tick stretches the strobe by one port clock
              o_strobe_rd_n <= 1'b1;
              o_strobe_wr_n <= 1'b1;
              if (!write_q) begin
                o_rdata       <= din_s2_q;
                o_rdata_valid <= 1'b1;
              end
              cnt_q   <= cnt_load(emp_pkg::CNT_W'(write_q ? cfg_q.write_hold_cycles
                                                          : cfg_q.read_hold_cycles));
              state_q <= emp_pkg::ST_AHOLD;
            end
          end
        end

        // Hold phase: strobe is high again but every select keeps its value;
        // the address is left as it was, which saves toggling the pins
        emp_pkg::ST_AHOLD: begin
          if (tick) begin
            if (cnt_q == emp_pkg::CNT_ZERO) begin
              // Hold count served; selects may now change
              o_chip_enable_n   <= emp_pkg::CE_IDLE;
              o_byte_enable_n   <= emp_pkg::BE_IDLE;
              o_output_enable_n <= 1'b1;
              o_data_oe         <= 1'b0;
              ready_q           <= 1'b1;
              state_q           <= emp_pkg::ST_IDLE;
            end else begin
              cnt_q <= cnt_q - emp_pkg::CNT_ONE;
            end
          end
        end

        // Synchronous command and latency: strobes last exactly one tick.
        // Chip enable stays low past the command only for a read with
        // select extension set, so glue logic in front of a FIFO sees it
        // for as long as the output enable is low
        emp_pkg::ST_SCMD: begin
          if (tick) begin
            // Command lasted one edge; chip enable follows extend setting
            o_strobe_rd_n <= 1'b1;
            o_strobe_wr_n <= 1'b1;
            if (!(cfg_q.select_extend && !write_q)) begin
              o_chip_enable_n <= emp_pkg::CE_IDLE;
            end
            if (write_q) begin
              if (cnt_q == emp_pkg::CNT_ONE) begin
                o_data    <= wdata_q;
                o_data_oe <= 1'b1;
              end else if (cnt_q == emp_pkg::CNT_ZERO) begin
                o_data_oe       <= 1'b0;
                o_byte_enable_n <= emp_pkg::BE_IDLE;
              end
            end else if (cnt_q == emp_pkg::CNT_ZERO) begin
              o_rdata           <= din_s2_q;
              o_rdata_valid     <= 1'b1;
              o_output_enable_n <= 1'b1;
              o_chip_enable_n   <= emp_pkg::CE_IDLE;
              o_byte_enable_n   <= emp_pkg::BE_IDLE;
            end
            if (cnt_q == emp_pkg::CNT_ZERO) begin
              if (cfg_q.read_enable_mode) begin
                ready_q <= 1'b1;
                state_q <= emp_pkg::ST_IDLE;
              end else begin
                state_q <= emp_pkg::ST_SDESEL;
              end
            end else begin
              cnt_q <= cnt_q - emp_pkg::CNT_ONE;
            end
          end
        end

        // Deselect: a spare tick between accesses for memories that need it
        emp_pkg::ST_SDESEL: begin
          // One port clock with every select idle before the next access
          if (tick) begin
            ready_q <= 1'b1;
            state_q <= emp_pkg::ST_IDLE;
          end
        end

        // Unused state codes fall back to idle and reopen the request port,
        // so a disturbed state register cannot hang the port
        default: begin
          state_q <= emp_pkg::ST_IDLE;
          ready_q <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Request port
  // ----------------------------------------------------------------------
  // Ready is a flop of its own, so the core sees a clean registered level
  assign o_req_ready = ready_q;

endmodule : emp_port

`default_nettype wire

// >>> sim/emp_port_properties.sv
// Concurrent checks on the pins of the external memory port
`timescale 1ns/1ns
`default_nettype none
module emp_port_properties (
  input wire logic                           i_clock,
  input wire logic                           i_rst,
  input wire logic                           i_async_ready,
  input wire logic                           o_rdata_valid,
  input wire logic [emp_pkg::NUM_SPACES-1:0] o_chip_enable_n,
  input wire logic [emp_pkg::BE_W-1:0]       o_byte_enable_n,
  input wire logic [emp_pkg::ADDR_W-1:0]     o_addr,
  input wire logic                           o_data_oe,
  input wire logic                           o_strobe_rd_n,
  input wire logic                           o_output_enable_n,
  input wire logic                           o_strobe_wr_n
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Helpers: any space selected, memory output enabled
  wire logic sel = ~&o_chip_enable_n;
  wire logic oe  = !o_output_enable_n;
  // Tick figures assume port clock a is 16 system clocks, as in the bench
  rd_setup_a: assert property ($fell(o_strobe_rd_n) && $past(oe)
    |-> $past(oe, 16)) else $error("read selects led strobe by under one tick");
  rd_hold_a: assert property ($rose(o_strobe_rd_n) && oe && o_rdata_valid
    |-> ##15 sel) else $error("read selects dropped within one tick of strobe end");
  wr_setup_a: assert property ($fell(o_strobe_wr_n) && $past(o_data_oe)
    |-> $past(o_data_oe, 16)) else $error("write selects led strobe by under one tick");
  wr_hold_a: assert property ($rose(o_strobe_wr_n) && o_data_oe && $past(o_data_oe, 16)
    |-> ##15 (o_data_oe && sel)) else $error("write selects dropped within one tick");
  strobe_tick_a: assert property ($changed({o_strobe_rd_n, o_strobe_wr_n})
    |=> $stable({o_strobe_rd_n, o_strobe_wr_n}) [*8]) else $error("strobe moved off a tick");
  rdata_edge_a: assert property (o_rdata_valid && oe
    |-> $rose(o_strobe_rd_n)) else $error("async read data not taken at strobe rise");
  ready_wait_a: assert property ($rose(o_strobe_rd_n) && oe && o_rdata_valid
    |-> $past(i_async_ready, 4)) else $error("strobe ended while ready was low");
  no_fight_a: assert property (o_data_oe
    |-> o_output_enable_n) else $error("data driven while memory output enabled");
  sel_stable_a: assert property (sel && $past(sel)
    |-> $stable(o_addr) && $stable(o_byte_enable_n)) else $error("selects moved mid-access");
  // Main scenarios: async read, async write, sync read
  cover property ($fell(o_strobe_rd_n) && $past(oe));
  cover property ($rose(o_strobe_wr_n) && o_data_oe);
  cover property (o_rdata_valid && !oe);
endmodule : emp_port_properties
bind emp_port emp_port_properties u_props (.i_clock, .i_rst, .i_async_ready, .o_rdata_valid,
  .o_chip_enable_n, .o_byte_enable_n, .o_addr, .o_data_oe, .o_strobe_rd_n,
  .o_output_enable_n, .o_strobe_wr_n);
`default_nettype wire

// >>> sim/emp_mem_model.sv
// Behavioural far-side memory with a ready line that can stall
`timescale 1ns/1ns
`default_nettype none
module emp_mem_model (
  input  wire logic        i_clock,
  input  wire logic        i_port_clk,
  input  wire logic        i_slow,
  input  wire logic [3:0]  i_be_n,
  input  wire logic [19:0] i_addr,
  input  wire logic [31:0] i_data,
  input  wire logic        i_data_oe,
  input  wire logic        i_oe_n,
  input  wire logic        i_rd_n,
  input  wire logic        i_wr_n,
  output logic [31:0]      o_data,
  output logic             o_ready
);
  logic [31:0] mem_q [16];
  logic [31:0] last_q = 32'h00000000;
  int          hold_q = 0;
  initial o_ready = 1'b1;
  // Store each enabled byte while the port drives the bus
  always @(posedge i_clock) begin
    for (int b = 0; b < 4; b++) begin
      if (i_data_oe && !i_be_n[b]) mem_q[i_addr[3:0]][b*8 +: 8] <= i_data[b*8 +: 8];
    end
    if (!i_oe_n) last_q <= mem_q[i_addr[3:0]];
  end
  // A released bus shows the inverse of its last value, so stale data never matches
  assign o_data = i_oe_n ? ~last_q : mem_q[i_addr[3:0]];
  // Ready changes mid-period only and each low level lasts three port clocks
  always @(negedge i_port_clk) begin
    if (hold_q == 1) begin
      o_ready <= 1'b1;
      hold_q <= 0;
    end else if (hold_q > 1) begin
      hold_q <= hold_q - 1;
    end else if (i_slow && !(i_rd_n && i_wr_n)) begin
      o_ready <= 1'b0;
      hold_q <= 3;
    end
  end
endmodule : emp_mem_model
`default_nettype wire

// >>> sim/emp_port_test.sv
// Self-checking bench for the external memory port sequencer
`timescale 1ns/1ns
`default_nettype none
module emp_port_test;
  logic                    clk = 1'b0;
  logic                    rst = 1'b1;
  logic                    pca = 1'b0;
  logic                    pcb = 1'b0;
  logic                    slow = 1'b0;
  logic                    req_valid = 1'b0;
  emp_pkg::emp_req_s       req = '0;
  emp_pkg::emp_space_cfg_s cfg [emp_pkg::NUM_SPACES];
  logic                    ready, rvalid, data_oe, rd_n, oe_n, wr_n, async_ready;
  logic [31:0]             rdata, dout, din, got;
  logic [3:0]              ce_n, be_n;
  logic [19:0]             addr;
  int                      n_errors = 0;
  int                      tests_run = 0;
  int                      d_valid, d_ready, d_oe, n_ce, n_rd, n_wr;
  // Port clock b is slower and out of phase so a wrong clock choice shows in timing
  initial forever #5 clk = ~clk;
  initial forever #80 pca = ~pca;
  initial begin
    #37;
    forever #120 pcb = ~pcb;
  end
  emp_port u_dut (.i_clock(clk), .i_rst(rst), .i_space_cfg(cfg), .i_req_valid(req_valid),
    .i_req(req), .o_req_ready(ready), .o_rdata_valid(rvalid), .o_rdata(rdata),
    .i_ext_clock_out_a(pca), .i_ext_clock_out_b(pcb), .i_async_ready(async_ready),
    .o_chip_enable_n(ce_n), .o_byte_enable_n(be_n), .o_addr(addr), .o_data(dout),
    .o_data_oe(data_oe), .i_data(din), .o_strobe_rd_n(rd_n), .o_output_enable_n(oe_n),
    .o_strobe_wr_n(wr_n));
  emp_mem_model u_mem (.i_clock(clk), .i_port_clk(pca), .i_slow(slow), .i_be_n(be_n),
    .i_addr(addr), .i_data(dout), .i_data_oe(data_oe), .i_oe_n(oe_n), .i_rd_n(rd_n),
    .i_wr_n(wr_n), .o_data(din), .o_ready(async_ready));
  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic results();
    $display("Checks run %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  task automatic aset(input int sp, rs, rt, rh, ws, wt, wh);
    cfg[sp] = '{1'b0, 4'(rs), 6'(rt), 3'(rh), 4'(ws), 6'(wt), 3'(wh), 2'h0, 2'h0, 1'b0,
                1'b0, 1'b0};
  endtask : aset
  // One access; event times are counted in clocks from the take
  task automatic acc(input logic w, input logic [1:0] sp, input logic [31:0] wd);
    int t;
    req = '{write: w, space: sp, addr: 20'h00010 + 20'(sp), byte_enable: 4'hf, wdata: wd};
    req_valid = 1'b1;
    for (t = 0; t < 400 && ready !== 1'b0; t++) begin
      @(posedge clk);
      #1;
    end
    req_valid = 1'b0;
    if (ready !== 1'b0) n_errors++;
    if (ready !== 1'b0) results();
    d_valid = -1;
    d_oe = -1;
    n_ce = 0;
    n_rd = 0;
    n_wr = 0;
    for (t = 0; t < 1000; t++) begin
      if (rvalid === 1'b1) d_valid = t;
      if (rvalid === 1'b1) got = rdata;
      if (data_oe === 1'b1 && d_oe < 0) d_oe = t;
      n_ce += int'(ce_n !== 4'hf);
      n_rd += int'(rd_n === 1'b0);
      n_wr += int'(wr_n === 1'b0);
      if (ready === 1'b1) break;
      @(posedge clk);
      #1;
    end
    d_ready = t;
    if (t == 1000) n_errors++;
    if (t == 1000) results();
  endtask : acc
  // Async write then read back in one space with its own counts
  task automatic t_async(input int sp, rs, rt, rh, ws, wt, wh);
    aset(sp, rs, rt, rh, ws, wt, wh);
    acc(1'b1, 2'(sp), 32'h5a5a0000 + sp);
    chk(d_ready, 16 * (ws + wt + wh));
    chk(n_wr, 16 * wt);
    chk(n_rd, 0);
    acc(1'b0, 2'(sp), 32'h0);
    chk(got, 32'h5a5a0000 + sp);
    chk(d_valid, 16 * (rs + rt));
    chk(d_ready, 16 * (rs + rt + rh));
    chk(n_rd, 16 * rt);
    $display("async space %0d done", sp);
  endtask : t_async
  // Memory holds ready low for three port clocks; strobe must wait it out
  task automatic t_ready();
    aset(0, 1, 2, 1, 1, 2, 1);
    slow = 1'b1;
    acc(1'b0, 2'h0, 32'h0);
    slow = 1'b0;
    chk(n_rd, 64);
    chk(got, 32'h5a5a0000);
    $display("ready stretch done");
  endtask : t_ready
  // Every latency, read-enable mode and select extension on one port clock
  task automatic t_sync(input int cs);
    int p;
    p = cs ? 24 : 16;
    for (int k = 0; k < 16; k++) begin
      cfg[1] = '{1'b1, 4'h1, 6'h01, 3'h1, 4'h1, 6'h01, 3'h1, 2'(k % 4), 2'(k % 4), 1'(k / 8),
                 1'((k / 4) % 2), 1'(cs)};
      acc(1'b1, 2'h1, 32'hc0de0000 + k);
      chk(d_oe, p * (k % 4));
      chk(d_ready, p * (k % 4 + 2 - (k / 4) % 2));
      chk(n_rd, (k / 4) % 2 ? 0 : p);
      chk(n_wr, p);
      acc(1'b0, 2'h1, 32'h0);
      chk(got, 32'hc0de0000 + k);
      chk(d_valid, p * (k % 4 + 1));
      chk(n_ce, k / 8 ? p * (k % 4 + 1) : p);
    end
    $display("sync on port clock %0d done", cs);
  endtask : t_sync
  initial begin
    for (int s = 0; s < 4; s++) aset(s, 1, 1, 1, 1, 1, 1);
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    chk(32'({ce_n, be_n, rd_n, oe_n, wr_n, data_oe, ready}), 32'h1ffd);
    chk(32'(addr), 32'h0);
    chk(dout, 32'h0);
    chk(rdata, 32'h0);
    $display("reset levels done");
    t_async(0, 1, 2, 1, 2, 1, 2);
    t_async(2, 3, 1, 2, 1, 3, 1);
    t_ready();
    t_sync(0);
    t_sync(1);
    results();
  end
endmodule : emp_port_test
`default_nettype wire
